// ### core/flash_lock_pkg.sv
// Package with the address map, lock-byte layout and access encodings of the Flash lock checker.
package flash_lock_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int PAGE_SHIFT = 10;
  localparam int PAGE_W = ADDR_W - PAGE_SHIFT;
  localparam logic [ADDR_W-1:0] LOCK_BYTE_ADDR = 16'hFBFF;
  localparam logic [PAGE_W-1:0] LOCK_PAGE = LOCK_BYTE_ADDR[ADDR_W-1:PAGE_SHIFT];
  localparam logic [PAGE_W-1:0] PAGE_COUNT = 6'h3F;
  localparam logic [ADDR_W-1:0] SCRATCH_BASE = 16'h0000;
  localparam logic [ADDR_W-1:0] SCRATCH_LAST = 16'h03FF;
  localparam int LOCK_W = 8;
  localparam int LOCK_GROUP_SHIFT = 3;
  localparam logic [LOCK_W-1:0] LOCK_ERASED = 8'hFF;

  // ----------------------------------------------------------------
  // Access encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_WRITE = 2'b01,
    OP_ERASE = 2'b10,
    OP_DEVICE_ERASE = 2'b11
  } flash_op_t;

  typedef enum logic [1:0] {
    VERDICT_ALLOW = 2'b00,
    VERDICT_IGNORE = 2'b01,
    VERDICT_RESET = 2'b10
  } verdict_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_ERASE = 2'b01,
    ST_RESET = 2'b10
  } ctl_state_t;

  localparam logic [7:0] ERASE_CYCLES = 8'h40;
  localparam logic [3:0] RESET_CYCLES = 4'h8;

endpackage : flash_lock_pkg

// ### core/page_lock_if.sv
// Interface carrying the lock-state view between the lock register and the checker.
interface page_lock_if;
  import flash_lock_pkg::*;
  logic [LOCK_W-1:0] lock_bits;
  logic any_locked;
  logic all_locked;
  modport owner (output lock_bits, output any_locked, output all_locked);
  modport user (input lock_bits, input any_locked, input all_locked);
endinterface : page_lock_if

// ### core/lock_state_reg.sv
// Lock state sampled from the stored lock byte at reset release.
module lock_state_reg
  import flash_lock_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [LOCK_W-1:0] stored_lock_byte,
  input wire logic wipe,
  page_lock_if.owner lk
);
  logic [LOCK_W-1:0] lock_reg;
  logic sampled_reg;

  // The stored value is taken only on the first edge after reset, so later
  // firmware writes stay invisible until the next reset.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lock_reg <= LOCK_ERASED;
      sampled_reg <= 1'b0;
    end
    else if (wipe)
    begin
      lock_reg <= LOCK_ERASED;
      sampled_reg <= 1'b1;
    end
    else if (!sampled_reg)
    begin
      lock_reg <= stored_lock_byte;
      sampled_reg <= 1'b1;
    end
  end

  assign lk.lock_bits = lock_reg;
  assign lk.any_locked = (lock_reg != LOCK_ERASED);
  assign lk.all_locked = (lock_reg == '0);
endmodule : lock_state_reg

// ### core/page_decode.sv
// Classifies one Flash address against the current lock state.
module page_decode
  import flash_lock_pkg::*;
(
  input wire logic [ADDR_W-1:0] addr,
  page_lock_if.user lk,
  output logic is_reserved,
  output logic is_lock_page,
  output logic is_lock_byte,
  output logic is_locked
);
  logic [PAGE_W-1:0] page;
  logic scratch;
  logic [2:0] grp;

  assign page = addr[ADDR_W-1:PAGE_SHIFT];
  assign grp = page[PAGE_W-1:LOCK_GROUP_SHIFT];
  assign scratch = 1'b0 && (addr >= SCRATCH_BASE) && (addr <= SCRATCH_LAST);
  assign is_reserved = addr > LOCK_BYTE_ADDR;
  assign is_lock_page = (page == LOCK_PAGE) && !is_reserved;
  assign is_lock_byte = addr == LOCK_BYTE_ADDR;

  // Each lock bit guards a group of pages; a zero bit means locked.
  always_comb
  begin
    if (is_lock_page)
      is_locked = lk.any_locked;
    else if (scratch)
      is_locked = lk.all_locked;
    else
      is_locked = !lk.lock_bits[grp];
  end
endmodule : page_decode

// ### core/flash_page_lock_checker.sv
// Top of the Flash access permission checker.
//
// What this block does
// - Unlocked ordinary pages open to every requester.
// - Locked pages: debug refused, unlocked firmware resets.
// - Lock page free until any page locks, bar firmware erase.
// - Lock byte reads follow locked-page treatment.
// - Lock page erase: debug only, firmware resets.
// - Locked lock page erased only by device erase.
// - Locking more pages is refused or resets.
// - Unlocking single pages is refused or resets.
// - Reserved area refused or resets.
// - Firmware violation resets; error flag reads one.
// - Debug violations are dropped, never reset.
// - Any locked page locks the lock page.
// - Programmed lock byte changes only via device erase.
// - Firmware lock writes act after next reset.
// - Scratchpad locked with pages 0 to 7 by lock bit 0.
// - Device erase also erases the scratchpad.
// - Lock byte is last address; above reserved.
module flash_page_lock_checker
  import flash_lock_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire logic req_from_debug,
  input wire flash_lock_pkg::flash_op_t req_op,
  input wire logic [flash_lock_pkg::ADDR_W-1:0] req_addr,
  input wire logic [flash_lock_pkg::LOCK_W-1:0] req_wdata,
  input wire logic [flash_lock_pkg::ADDR_W-1:0] exec_addr,
  input wire logic [flash_lock_pkg::LOCK_W-1:0] stored_lock_byte,
  output logic grant,
  output logic ignored_reg,
  output logic flash_op_go_reg,
  output logic scratch_erase_go_reg,
  output logic flash_error_device_reset_reg,
  output logic flash_error_reset_flag_reg,
  output logic [flash_lock_pkg::LOCK_W-1:0] lock_view
);
  import flash_lock_pkg::*;

  // ----------------------------------------------------------------
  // Lock state and address classification
  // ----------------------------------------------------------------
  page_lock_if lk ();
  logic wipe;
  logic t_res, t_lpage, t_lbyte, t_locked;
  logic x_res, x_lpage, x_lbyte, x_locked;
  ctl_state_t state_reg;
  logic [7:0] count_reg;
  logic err_seen_reg;

  lock_state_reg u_lock (
    .core_clk(core_clk),
    .nrst(nrst),
    .stored_lock_byte(stored_lock_byte),
    .wipe(wipe),
    .lk(lk)
  );

  page_decode u_target (
    .addr(req_addr),
    .lk(lk),
    .is_reserved(t_res),
    .is_lock_page(t_lpage),
    .is_lock_byte(t_lbyte),
    .is_locked(t_locked)
  );

  page_decode u_exec (
    .addr(exec_addr),
    .lk(lk),
    .is_reserved(x_res),
    .is_lock_page(x_lpage),
    .is_lock_byte(x_lbyte),
    .is_locked(x_locked)
  );

  assign lock_view = lk.lock_bits;

  // ----------------------------------------------------------------
  // Permission decision
  // ----------------------------------------------------------------
  verdict_t verdict;
  logic fw_ok;

  // Firmware on a locked page may touch locked areas; an unlocked page may not.
  assign fw_ok = x_locked;

  always_comb
  begin
    verdict = VERDICT_ALLOW;
    if (req_op == OP_DEVICE_ERASE)
      verdict = req_from_debug ? VERDICT_ALLOW : VERDICT_RESET;
    else if (t_res)
      verdict = req_from_debug ? VERDICT_IGNORE : VERDICT_RESET;
    else if (t_lpage && req_op == OP_ERASE)
    begin
      if (!req_from_debug)
        verdict = VERDICT_RESET;
      else if (lk.any_locked)
        verdict = VERDICT_IGNORE;
    end
    else if (t_lbyte && req_op == OP_WRITE)
    begin
      // Only the first programming of an erased lock byte is accepted.
      if (stored_lock_byte != LOCK_ERASED || lk.any_locked)
        verdict = req_from_debug ? VERDICT_IGNORE : VERDICT_RESET;
    end
    else if (t_locked && !(t_lbyte && !lk.any_locked))
    begin
      if (req_from_debug)
        verdict = VERDICT_IGNORE;
      else if (!fw_ok)
        verdict = VERDICT_RESET;
    end
    else
      verdict = VERDICT_ALLOW;
  end

  assign grant = req_valid && state_reg == ST_RUN && verdict == VERDICT_ALLOW;

  // ----------------------------------------------------------------
  // Control sequence
  // ----------------------------------------------------------------
  // The device erase runs a fixed time, then wipes the sampled lock state.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= ST_RUN;
      count_reg <= 8'h00;
    end
    else
    begin
      case (state_reg)
        ST_RUN:
        begin
          if (req_valid && verdict == VERDICT_RESET)
          begin
            state_reg <= ST_RESET;
            count_reg <= {4'h0, RESET_CYCLES};
          end
          else if (grant && req_op == OP_DEVICE_ERASE)
          begin
            state_reg <= ST_ERASE;
            count_reg <= ERASE_CYCLES;
          end
        end
        ST_ERASE, ST_RESET:
        begin
          if (count_reg == 8'h01)
            state_reg <= ST_RUN;
          count_reg <= count_reg - 8'h01;
        end
        default:
          state_reg <= ST_RUN;
      endcase
    end
  end

  assign wipe = state_reg == ST_ERASE && count_reg == 8'h01;

  // Per-access result strobes, one cycle each.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ignored_reg <= 1'b0;
      flash_op_go_reg <= 1'b0;
      scratch_erase_go_reg <= 1'b0;
    end
    else
    begin
      ignored_reg <= req_valid && state_reg == ST_RUN && verdict == VERDICT_IGNORE;
      flash_op_go_reg <= grant;
      scratch_erase_go_reg <= grant && req_op == OP_DEVICE_ERASE;
    end
  end

  // Reset request held while the reset sequence counts down.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      flash_error_device_reset_reg <= 1'b0;
    else
      flash_error_device_reset_reg <= (state_reg == ST_RESET) && count_reg != 8'h01;
  end

  // The error cause is recorded here, and the flag rises on the same edge as the
  // reset request it triggers, so it can be read before the system is reset.
  // The marker is on the same reset; the reset source register outside keeps it.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      err_seen_reg <= 1'b0;
      flash_error_reset_flag_reg <= 1'b0;
    end
    else
    begin
      if (state_reg == ST_RUN && req_valid && verdict == VERDICT_RESET)
        err_seen_reg <= 1'b1;
      else if (state_reg == ST_RUN && req_valid && verdict == VERDICT_ALLOW)
        err_seen_reg <= 1'b0;
      flash_error_reset_flag_reg <= err_seen_reg;
    end
  end

  logic unused_x;
  assign unused_x = x_res ^ x_lpage ^ x_lbyte ^ (|req_wdata);
endmodule : flash_page_lock_checker

// ### test/flash_lock_checker_properties.sv
// Concurrent checks on the ports of the Flash page lock checker.
module flash_lock_checker_properties
  import flash_lock_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire logic req_from_debug,
  input wire flash_lock_pkg::flash_op_t req_op,
  input wire logic [flash_lock_pkg::ADDR_W-1:0] req_addr,
  input wire logic grant,
  input wire logic ignored_reg,
  input wire logic flash_op_go_reg,
  input wire logic scratch_erase_go_reg,
  input wire logic flash_error_device_reset_reg,
  input wire logic flash_error_reset_flag_reg,
  input wire logic [flash_lock_pkg::LOCK_W-1:0] lock_view
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  // Strobes must trace back to the decision taken one edge before.
  grant_go_a: assert property (req_valid && grant |=> flash_op_go_reg)
    else $error("granted access not started");
  go_cause_a: assert property (flash_op_go_reg |-> $past(req_valid && grant))
    else $error("access started without grant");
  ignore_cause_a: assert property (ignored_reg |-> $past(req_valid && req_from_debug && !grant))
    else $error("ignore strobe without refused debug access");
  scratch_go_a: assert property (scratch_erase_go_reg |-> $past(grant && req_op == OP_DEVICE_ERASE))
    else $error("scratch erase without device erase grant");
  // A debug request can never be the cause of the reset sequence.
  debug_no_reset_a: assert property ($rose(flash_error_device_reset_reg) |-> $past(req_valid && !req_from_debug, 2))
    else $error("reset not caused by firmware request");
  reset_len_a: assert property ($rose(flash_error_device_reset_reg) |-> flash_error_device_reset_reg[*7] ##1 !flash_error_device_reset_reg)
    else $error("reset request length wrong");
  flag_set_a: assert property ($rose(flash_error_device_reset_reg) |-> flash_error_reset_flag_reg)
    else $error("error flag missing with reset");
  // Refusals; all but the lock page check hold whatever the lock state is.
  reserved_no_a: assert property (req_valid && req_addr > LOCK_BYTE_ADDR |-> !grant)
    else $error("reserved area granted");
  fw_erase_no_a: assert property (req_valid && !req_from_debug && (req_op == OP_DEVICE_ERASE || (req_op == OP_ERASE && req_addr[ADDR_W-1:PAGE_SHIFT] == LOCK_PAGE)) |-> !grant)
    else $error("firmware erase of lock page granted");
  lock_page_no_a: assert property (req_valid && req_from_debug && lock_view != LOCK_ERASED && req_addr[ADDR_W-1:PAGE_SHIFT] == LOCK_PAGE && req_op != OP_DEVICE_ERASE |-> !grant)
    else $error("lock page open to debug while locked");

  // Main scenarios reached.
  cover property (ignored_reg);
  cover property ($rose(flash_error_device_reset_reg));
  cover property (scratch_erase_go_reg);
endmodule : flash_lock_checker_properties

bind flash_page_lock_checker flash_lock_checker_properties u_props (
  .core_clk(core_clk), .nrst(nrst), .req_valid(req_valid), .req_from_debug(req_from_debug),
  .req_op(req_op), .req_addr(req_addr), .grant(grant), .ignored_reg(ignored_reg),
  .flash_op_go_reg(flash_op_go_reg), .scratch_erase_go_reg(scratch_erase_go_reg),
  .flash_error_device_reset_reg(flash_error_device_reset_reg),
  .flash_error_reset_flag_reg(flash_error_reset_flag_reg), .lock_view(lock_view)
);

// ### test/flash_store_model.sv
// Behavioural model of the Flash cell that holds the lock byte.
module flash_store_model
  import flash_lock_pkg::*;
(
  input wire logic core_clk,
  input wire logic wipe,
  input wire logic load,
  input wire logic [flash_lock_pkg::LOCK_W-1:0] load_value,
  output logic [flash_lock_pkg::LOCK_W-1:0] stored_lock_byte
);
  timeunit 1ns;
  timeprecision 100ps;
  // Non-volatile, so no reset; a lock write lands only on an erased cell.
  initial stored_lock_byte = LOCK_ERASED;
  always @(posedge core_clk)
    if (wipe)
      stored_lock_byte <= LOCK_ERASED;
    else if (load && stored_lock_byte == LOCK_ERASED)
      stored_lock_byte <= load_value;
endmodule : flash_store_model

// ### test/flash_page_lock_checker_test.sv
// Self-checking bench for the Flash page lock checker.
module flash_page_lock_checker_test
  import flash_lock_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  logic dbg = 1'b0;
  logic ld = 1'b0;
  flash_op_t op = OP_READ;
  logic [15:0] addr = 16'h0000;
  logic [15:0] exec = 16'h0000;
  logic [7:0] ld_val = 8'hFF;
  logic grant, ign, go, sgo, frst, flag;
  logic [7:0] lock_byte, lock_view;
  int n_mismatch = 0;
  int n_checks = 0;

  always #12.5 core_clk = ~core_clk;

  flash_store_model u_flash (.core_clk(core_clk), .wipe(sgo), .load(ld), .load_value(ld_val),
    .stored_lock_byte(lock_byte));
  flash_page_lock_checker u_dut (.core_clk(core_clk), .nrst(nrst), .req_valid(req_valid),
    .req_from_debug(dbg), .req_op(op), .req_addr(addr), .req_wdata(8'h00), .exec_addr(exec),
    .stored_lock_byte(lock_byte), .grant(grant), .ignored_reg(ign), .flash_op_go_reg(go),
    .scratch_erase_go_reg(sgo), .flash_error_device_reset_reg(frst),
    .flash_error_reset_flag_reg(flag), .lock_view(lock_view));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  // Reset is held three cycles; the lock byte is sampled on the first edge after.
  task automatic do_reset();
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask

  // One request; k is 0 for grant, 1 for silent drop, 2 for reset sequence.
  task automatic acc(input logic d, input flash_op_t o, input logic [15:0] a, e, input int k);
    int n;
    @(posedge core_clk);
    dbg <= d;
    op <= o;
    addr <= a;
    exec <= e;
    req_valid <= 1'b1;
    @(negedge core_clk);
    check("grant", 8'(k == 0), grant);
    @(posedge core_clk);
    req_valid <= 1'b0;
    @(negedge core_clk);
    check("go", 8'(k == 0), go);
    check("ignored", 8'(k == 1), ign);
    check("scratch", 8'(k == 0 && o == OP_DEVICE_ERASE), sgo);
    n = 0;
    repeat (9)
    begin
      @(negedge core_clk);
      n += int'(frst);
    end
    check("reset_len", (k == 2) ? 8'h07 : 8'h00, 8'(n));
    check("flag", 8'(k == 2), flag);
    // The flag would be lost in a real reset, so it is judged first.
    if (k == 2)
      do_reset();
  endtask

  task automatic t_open();
    check("lock_view", 8'hFF, lock_view);
    acc(1'b1, OP_READ, 16'h0400, 16'h0000, 0);
    acc(1'b0, OP_WRITE, 16'h2000, 16'h0400, 0);
    acc(1'b1, OP_READ, 16'hFBFF, 16'h0000, 0);
    acc(1'b1, OP_ERASE, 16'hF800, 16'h0000, 0);
  endtask

  task automatic t_refuse();
    acc(1'b1, OP_READ, 16'hFC00, 16'h0000, 1);
    acc(1'b0, OP_WRITE, 16'hFFFF, 16'h0400, 2);
    acc(1'b0, OP_ERASE, 16'hF800, 16'h0400, 2);
    acc(1'b0, OP_DEVICE_ERASE, 16'h0000, 16'h0400, 2);
  endtask

  // Pages 0 to 7 get locked; the effect must wait for the next reset.
  task automatic t_lock();
    @(posedge core_clk);
    ld <= 1'b1;
    ld_val <= 8'hFE;
    @(posedge core_clk);
    ld <= 1'b0;
    acc(1'b1, OP_READ, 16'h0400, 16'h0000, 0);
    do_reset();
    check("lock_view", 8'hFE, lock_view);
    acc(1'b1, OP_READ, 16'h0400, 16'h0000, 1);
    acc(1'b0, OP_READ, 16'h0800, 16'h0400, 0);
    acc(1'b0, OP_READ, 16'h0400, 16'h2000, 2);
    acc(1'b1, OP_WRITE, 16'hF800, 16'h0000, 1);
    acc(1'b1, OP_READ, 16'hFBFF, 16'h0000, 1);
    acc(1'b0, OP_READ, 16'hFBFF, 16'h0000, 0);
    acc(1'b1, OP_WRITE, 16'hFBFF, 16'h0000, 1);
    acc(1'b0, OP_WRITE, 16'hFBFF, 16'h0000, 2);
    acc(1'b1, OP_ERASE, 16'hF800, 16'h0000, 1);
  endtask

  // Only a debug device erase reopens the part.
  task automatic t_wipe();
    acc(1'b1, OP_DEVICE_ERASE, 16'h0000, 16'h0000, 0);
    repeat (70) @(posedge core_clk);
    do_reset();
    check("lock_view", 8'hFF, lock_view);
    acc(1'b1, OP_READ, 16'h0400, 16'h0000, 0);
  endtask

  initial
  begin
    do_reset();
    t_open();
    t_refuse();
    t_lock();
    t_wipe();
    report_and_stop();
  end

  // Watchdog well beyond the few hundred cycles the tests take.
  initial
  begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
endmodule : flash_page_lock_checker_test
